// ===== iat_conv_unit.sv
// one converter unit: armed by its trigger, then scans continuously
module iat_conv_unit (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [iat_pkg::RES_W-1:0] sampleIn,
    iat_unit_if.unit bus
);
    logic [iat_pkg::RES_W-1:0] syncA_r;
    logic [iat_pkg::RES_W-1:0] syncB_r;
    iat_pkg::iat_unit_state_t state_r;
    iat_pkg::iat_unit_state_t state_nxt;
    logic [iat_pkg::SSC_W:0] tick_r;
    logic [iat_pkg::SSC_W:0] tick_nxt;
    logic [iat_pkg::RES_W-1:0] result_r;
    logic sampleDone;

    // sampling spans ssc+0.5 converter clocks, rounded up to ssc+1 ticks
    assign sampleDone = bus.convTick && (tick_r == {1'b0, bus.ssc});
    assign bus.scanEnd = (state_r == iat_pkg::IAT_DONE);
    assign bus.busy = (state_r != iat_pkg::IAT_IDLE);
    assign bus.result = result_r;

    always_comb begin
        state_nxt = state_r;
        tick_nxt = tick_r;
        case (state_r)
            iat_pkg::IAT_IDLE: begin
                tick_nxt = '0;
                if (bus.trig && bus.enable) begin
                    state_nxt = iat_pkg::IAT_SAMPLE;
                end
            end
            iat_pkg::IAT_SAMPLE: begin
                if (!bus.enable) begin
                    state_nxt = iat_pkg::IAT_IDLE;
                end else if (sampleDone) begin
                    state_nxt = iat_pkg::IAT_DONE;
                end else if (bus.convTick) begin
                    tick_nxt = tick_r + 1'b1;
                end
            end
            iat_pkg::IAT_DONE: begin
                tick_nxt = '0;
                // continuous scan: next scan starts with no new trigger
                state_nxt = bus.enable ? iat_pkg::IAT_SAMPLE : iat_pkg::IAT_IDLE;
            end
            default: begin
                state_nxt = iat_pkg::IAT_IDLE;
                tick_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            syncA_r <= '0;
            syncB_r <= '0;
            state_r <= iat_pkg::IAT_IDLE;
            tick_r <= '0;
        end else begin
            syncA_r <= sampleIn;
            syncB_r <= syncA_r;
            state_r <= state_nxt;
            tick_r <= tick_nxt;
        end
    end

    // a new result wins over a clearing read in the same cycle
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            result_r <= '0;
        end else if (sampleDone && state_r == iat_pkg::IAT_SAMPLE) begin
            result_r <= syncB_r;
        end else if (bus.readClr) begin
            result_r <= '0;
        end
    end
endmodule // iat_conv_unit

// ===== iat_far_side.sv
// analog source for both units and a transfer engine counting scan end requests
module iat_far_side (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [11:0] lvl0,
    input wire logic [11:0] lvl1,
    input wire logic dmaReq0,
    input wire logic dmaReq1,
    output logic [11:0] sample0,
    output logic [11:0] sample1,
    output logic [7:0] n0
);
    timeunit 1ns;
    timeprecision 1ns;
    assign sample0 = lvl0;
    assign sample1 = lvl1;
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            n0 <= 8'h00;
        end else if (dmaReq0 || dmaReq1) begin
            n0 <= n0 + 8'h01;
        end
    end
endmodule // iat_far_side

// ===== iat_pkg.sv
// constants, register map and types shared by the interleaved trigger block
package iat_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int RES_W = 12;
    localparam int CNT_W = 16;
    localparam int SSC_W = 8;
    localparam int EVT_W = 3;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_PERIOD = 8'h04;
    localparam logic [7:0] OFS_SSC = 8'h08;
    localparam logic [7:0] OFS_RES0 = 8'h0C;
    localparam logic [7:0] OFS_RES1 = 8'h10;
    localparam logic [7:0] OFS_STAT = 8'h14;
    localparam logic [7:0] OFS_MASK = 8'h18;
    localparam logic [7:0] OFS_STATE = 8'h1C;

    // control field positions
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_ONESHOT_BIT = 1;
    localparam int CTRL_ENABLE_BIT = 2;

    // event bit positions in status and mask
    localparam int EVT_SCAN0_BIT = 0;
    localparam int EVT_SCAN1_BIT = 1;
    localparam int EVT_OVF_BIT = 2;

    // state register field positions
    localparam int ST_RUN_BIT = 0;
    localparam int ST_BUSY0_BIT = 1;
    localparam int ST_BUSY1_BIT = 2;
    localparam int ST_SHORT_BIT = 3;

    // reset values
    localparam logic [SSC_W-1:0] SSC_RESET = 8'h0B;
    localparam logic [2:0] CTRL_RESET = 3'h2;
    localparam logic [EVT_W-1:0] MASK_RESET = 3'h0;

    // timing: system clock, converter clock and default trigger delay
    localparam int SYS_CLK_NS = 50;
    localparam int CONV_CLK_DIV = 1;
    localparam int PERIPHERAL_CLOCK_C_MARGIN_CYC = 2;
    localparam int TRIG_DELAY_NS = 230;
    localparam logic [CNT_W-1:0] PERIOD_RESET =
        CNT_W'((TRIG_DELAY_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);

    typedef enum logic [2:0] {
        IAT_IDLE = 3'b001,
        IAT_SAMPLE = 3'b010,
        IAT_DONE = 3'b100
    } iat_unit_state_t;
endpackage

// ===== iat_trigger.sv
// interleaved converter trigger: timer, two units, registers and interrupt
//
// The implementer's own choices: the register addresses and the plain strobed port.
module iat_trigger (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [iat_pkg::ADDR_W-1:0] regAddr,
    input wire logic [iat_pkg::DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [iat_pkg::DATA_W-1:0] regRdata,
    input wire logic [iat_pkg::RES_W-1:0] sample0,
    input wire logic [iat_pkg::RES_W-1:0] sample1,
    output logic dmaReq0,
    output logic dmaReq1,
    output logic irq
);
    iat_unit_if u0 ();
    iat_unit_if u1 ();

    logic [2:0] ctrl_r;
    logic [iat_pkg::CNT_W-1:0] period_r;
    logic [iat_pkg::SSC_W-1:0] ssc_r;
    logic [iat_pkg::EVT_W-1:0] stat_r;
    logic [iat_pkg::EVT_W-1:0] stat_nxt;
    logic [iat_pkg::EVT_W-1:0] mask_r;
    logic [iat_pkg::DATA_W-1:0] regRdata_r;
    logic [iat_pkg::DATA_W-1:0] rdMux;
    logic [iat_pkg::CNT_W-1:0] cnt_r;
    logic [iat_pkg::CNT_W-1:0] cnt_nxt;
    logic run_r;
    logic run_nxt;
    logic cmpA;
    logic ovf;
    logic [7:0] div_r;
    logic convTick;
    logic [iat_pkg::EVT_W-1:0] evt;
    logic tooShort;

    wire selCtrl = (regAddr == iat_pkg::OFS_CTRL);
    wire selPeriod = (regAddr == iat_pkg::OFS_PERIOD);
    wire selSsc = (regAddr == iat_pkg::OFS_SSC);
    wire selRes0 = (regAddr == iat_pkg::OFS_RES0);
    wire selRes1 = (regAddr == iat_pkg::OFS_RES1);
    wire selStat = (regAddr == iat_pkg::OFS_STAT);
    wire selMask = (regAddr == iat_pkg::OFS_MASK);
    wire selState = (regAddr == iat_pkg::OFS_STATE);
    wire startWr = regWr && selCtrl && regWdata[iat_pkg::CTRL_RUN_BIT];

    // converter clock as an enable pulse divided from the system clock
    assign convTick = (div_r == 8'(iat_pkg::CONV_CLK_DIV - 1));

    // timer events: compare-match at half period, overflow at the end
    assign cmpA = run_r && (cnt_r == (period_r >> 1));
    assign ovf = run_r && (cnt_r == period_r - 1'b1);

    always_comb begin
        cnt_nxt = cnt_r;
        run_nxt = run_r;
        if (startWr) begin
            cnt_nxt = '0;
            run_nxt = 1'b1;
        end else if (ovf) begin
            cnt_nxt = '0;
            run_nxt = !ctrl_r[iat_pkg::CTRL_ONESHOT_BIT];
        end else if (run_r) begin
            cnt_nxt = cnt_r + 1'b1;
        end
    end

    // flags a period shorter than sampling time plus the peripheral margin
    assign tooShort = ({1'b0, period_r} <
        (17'(ssc_r) + 17'd1) * 17'(iat_pkg::CONV_CLK_DIV) + 17'(iat_pkg::PERIPHERAL_CLOCK_C_MARGIN_CYC));

    assign u0.trig = cmpA;
    assign u1.trig = ovf;
    assign u0.enable = ctrl_r[iat_pkg::CTRL_ENABLE_BIT];
    assign u1.enable = ctrl_r[iat_pkg::CTRL_ENABLE_BIT];
    assign u0.convTick = convTick;
    assign u1.convTick = convTick;
    assign u0.ssc = ssc_r;
    assign u1.ssc = ssc_r;
    assign u0.readClr = regRd && selRes0;
    assign u1.readClr = regRd && selRes1;

    iat_conv_unit unitZero (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .sampleIn(sample0),
        .bus(u0.unit)
    );

    iat_conv_unit unitOne (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .sampleIn(sample1),
        .bus(u1.unit)
    );

    // transfer requests bypass the interrupt mask
    assign dmaReq0 = u0.scanEnd;
    assign dmaReq1 = u1.scanEnd;

    assign evt[iat_pkg::EVT_SCAN0_BIT] = u0.scanEnd;
    assign evt[iat_pkg::EVT_SCAN1_BIT] = u1.scanEnd;
    assign evt[iat_pkg::EVT_OVF_BIT] = ovf;
    // events set over a clearing read
    assign stat_nxt = ((regRd && selStat) ? '0 : stat_r) | evt;
    assign irq = |(stat_r & mask_r);

    always_comb begin
        rdMux = '0;
        if (selCtrl) begin
            rdMux[2:0] = ctrl_r;
        end else if (selPeriod) begin
            rdMux[iat_pkg::CNT_W-1:0] = period_r;
        end else if (selSsc) begin
            rdMux[iat_pkg::SSC_W-1:0] = ssc_r;
        end else if (selRes0) begin
            rdMux[iat_pkg::RES_W-1:0] = u0.result;
        end else if (selRes1) begin
            rdMux[iat_pkg::RES_W-1:0] = u1.result;
        end else if (selStat) begin
            rdMux[iat_pkg::EVT_W-1:0] = stat_r;
        end else if (selMask) begin
            rdMux[iat_pkg::EVT_W-1:0] = mask_r;
        end else if (selState) begin
            rdMux[iat_pkg::ST_RUN_BIT] = run_r;
            rdMux[iat_pkg::ST_BUSY0_BIT] = u0.busy;
            rdMux[iat_pkg::ST_BUSY1_BIT] = u1.busy;
            rdMux[iat_pkg::ST_SHORT_BIT] = tooShort;
        end
    end
    assign regRdata = regRdata_r;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            div_r <= '0;
            cnt_r <= '0;
            run_r <= 1'b0;
            stat_r <= '0;
            regRdata_r <= '0;
        end else begin
            div_r <= convTick ? 8'h00 : div_r + 8'h01;
            cnt_r <= cnt_nxt;
            run_r <= run_nxt;
            stat_r <= stat_nxt;
            regRdata_r <= regRd ? rdMux : '0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r <= iat_pkg::CTRL_RESET;
            period_r <= iat_pkg::PERIOD_RESET;
            ssc_r <= iat_pkg::SSC_RESET;
            mask_r <= iat_pkg::MASK_RESET;
        end else if (regWr) begin
            if (selCtrl) ctrl_r <= regWdata[2:0];
            if (selPeriod) period_r <= regWdata[iat_pkg::CNT_W-1:0];
            if (selSsc) ssc_r <= regWdata[iat_pkg::SSC_W-1:0];
            if (selMask) mask_r <= regWdata[iat_pkg::EVT_W-1:0];
        end
    end
endmodule // iat_trigger

// ===== iat_trigger_bench.sv
// self-checking bench for the interleaved trigger block
`define CHK(a, b) begin testsRun++; if ((a) !== (b)) begin mismatches++; \
    $display("wrong value at %0t: %h expected %h", $time, a, b); end end
module iat_trigger_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, rstn, regWr, regRd, dmaReq0, dmaReq1, irq;
    logic [7:0] regAddr, n0;
    logic [31:0] regWdata, regRdata, d;
    logic [11:0] sample0, sample1, lvl0, lvl1;
    int mismatches, testsRun, cyc, g1, g0;
    iat_trigger DUT (.sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sample0(sample0), .sample1(sample1),
        .dmaReq0(dmaReq0), .dmaReq1(dmaReq1), .irq(irq));
    iat_far_side FAR (.sys_clk(sys_clk), .rstn(rstn), .lvl0(lvl0), .lvl1(lvl1), .dmaReq0(dmaReq0),
        .dmaReq1(dmaReq1), .sample0(sample0), .sample1(sample1), .n0(n0));
    task automatic stopTest;
        $display("mismatches %0d comparisons %0d", mismatches, testsRun);
        if (mismatches == 0 && testsRun > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= v;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRd <= 1'b0;
        @(negedge sys_clk);
        d = regRdata;
    endtask
    // waits for a unit zero request, then times unit one and the next unit zero request
    task automatic gaps;
        int k;
        k = 0;
        while (dmaReq0 !== 1'b1 && k < 300) begin
            @(negedge sys_clk);
            k++;
        end
        `CHK(dmaReq0, 1'b1)
        g1 = 0;
        g0 = 0;
        for (int i = 1; i < 100 && g0 == 0; i++) begin
            @(negedge sys_clk);
            if (dmaReq1 === 1'b1 && g1 == 0) g1 = i;
            if (dmaReq0 === 1'b1) g0 = i;
        end
    endtask
    task automatic tReset;
        rd(iat_pkg::OFS_CTRL);
        `CHK(d, 32'h2)
        rd(iat_pkg::OFS_PERIOD);
        `CHK(d, 32'h5)
        rd(iat_pkg::OFS_SSC);
        `CHK(d, 32'hB)
        rd(iat_pkg::OFS_STATE);
        `CHK(d, 32'h8)
        rd(iat_pkg::OFS_RES0);
        `CHK(d, 32'h0)
        rd(8'h20);
        `CHK(d, 32'h0)
    endtask
    task automatic tScan;
        lvl0 <= 12'hABC;
        lvl1 <= 12'h123;
        repeat (20) @(negedge sys_clk);
        `CHK(n0, 8'h00)
        wr(iat_pkg::OFS_CTRL, 32'h7);
        gaps();
        `CHK(g1, 2)
        `CHK(g0, 13)
        `CHK(irq, 1'b0)
        rd(iat_pkg::OFS_RES0);
        `CHK(d, 32'hABC)
        rd(iat_pkg::OFS_RES0);
        `CHK(d, 32'h0)
        rd(iat_pkg::OFS_RES1);
        `CHK(d, 32'h123)
        rd(iat_pkg::OFS_STAT);
        `CHK(d, 32'h7)
        rd(iat_pkg::OFS_STATE);
        `CHK(d, 32'hE)
    endtask
    task automatic tIrq;
        wr(iat_pkg::OFS_MASK, 32'h1);
        gaps();
        `CHK(irq, 1'b1)
        rd(iat_pkg::OFS_STAT);
        `CHK(d[0], 1'b1)
        `CHK(irq, 1'b0)
        wr(iat_pkg::OFS_MASK, 32'h0);
        `CHK(n0 > 8'h04, 1'b1)
    endtask
    task automatic tSsc;
        wr(iat_pkg::OFS_CTRL, 32'h2);
        wr(iat_pkg::OFS_SSC, 32'h3);
        rd(iat_pkg::OFS_STATE);
        `CHK(d[3], 1'b1)
        wr(iat_pkg::OFS_PERIOD, 32'h6);
        rd(iat_pkg::OFS_STATE);
        `CHK(d[3], 1'b0)
        wr(iat_pkg::OFS_PERIOD, 32'h9);
        wr(iat_pkg::OFS_CTRL, 32'h7);
        gaps();
        `CHK(g1, 4)
        `CHK(g0, 5)
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            stopTest();
        end
    end
    initial begin
        rstn = 1'b0;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 8'h00;
        regWdata = 32'h0;
        lvl0 = 12'h000;
        lvl1 = 12'h000;
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        tReset();
        tScan();
        tIrq();
        tSsc();
        stopTest();
    end
endmodule // iat_trigger_bench

// ===== iat_trigger_sva.sv
// assertion checker for the interleaved trigger block
module iat_trigger_chk (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regRdata,
    input wire logic [11:0] sample0,
    input wire logic [11:0] sample1,
    input wire logic dmaReq0,
    input wire logic dmaReq1,
    input wire logic irq
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    logic armed_r, maskZero_r, mask0_r, seen0_r;
    wire ctrlWr = regWr && regAddr == iat_pkg::OFS_CTRL;
    wire maskWr = regWr && regAddr == iat_pkg::OFS_MASK;
    wire resRd = regRd && (regAddr == iat_pkg::OFS_RES0 || regAddr == iat_pkg::OFS_RES1);
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            armed_r <= 1'b0;
            maskZero_r <= 1'b1;
            mask0_r <= 1'b0;
            seen0_r <= 1'b0;
        end else begin
            armed_r <= armed_r || (ctrlWr && regWdata[0] && regWdata[2]);
            maskZero_r <= maskWr ? regWdata[2:0] == 3'h0 : maskZero_r;
            mask0_r <= maskWr ? regWdata[0] : mask0_r;
            seen0_r <= seen0_r || dmaReq0;
        end
    end
    a_rdata_idle: assert property (!regRd |=> regRdata == 32'h0)
        else $error("read data not zero outside a read");
    a_result_width: assert property (resRd |=> regRdata[31:12] == 20'h0)
        else $error("result wider than twelve bits");
    a_no_early_scan: assert property (!armed_r |-> !dmaReq0 && !dmaReq1)
        else $error("scan end before any trigger");
    a_req_one_cycle: assert property (dmaReq0 |=> !dmaReq0 [*2])
        else $error("scan end request too long");
    a_req1_single: assert property ($rose(dmaReq1) |=> !dmaReq1)
        else $error("unit one request too long");
    a_unit_order: assert property (dmaReq1 |-> seen0_r)
        else $error("unit one finished before unit zero");
    a_irq_masked: assert property (maskZero_r |-> !irq)
        else $error("interrupt while fully masked");
    a_irq_follows: assert property (mask0_r && dmaReq0 |-> ##[0:2] irq)
        else $error("no interrupt after unmasked scan end");
    c_req0: cover property (dmaReq0);
    c_req1: cover property (dmaReq1);
    c_irq: cover property (irq);
endmodule // iat_trigger_chk

bind iat_trigger iat_trigger_chk u_chk (.sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sample0(sample0),
    .sample1(sample1), .dmaReq0(dmaReq0), .dmaReq1(dmaReq1), .irq(irq));

// ===== iat_unit_if.sv
// signals between the trigger controller and one converter unit
interface iat_unit_if;
    logic trig;
    logic enable;
    logic convTick;
    logic readClr;
    logic [iat_pkg::SSC_W-1:0] ssc;
    logic scanEnd;
    logic busy;
    logic [iat_pkg::RES_W-1:0] result;

    modport unit (input trig, input enable, input convTick, input readClr, input ssc,
                  output scanEnd, output busy, output result);
    modport ctrl (output trig, output enable, output convTick, output readClr, output ssc,
                  input scanEnd, input busy, input result);
endinterface
